// file: rtl/eic_pkg.sv
package eic_pkg;

    // Register byte addresses
    localparam logic [15:0] EXT_CTRL_ADDR = 16'h0018;
    localparam logic [15:0] CAUSE_ADDR = 16'h00c0;
    localparam logic [15:0] MASK_ADDR = 16'h00d0;
    localparam logic [15:0] MODE_ADDR = 16'h00e0;
    localparam logic [15:0] DELAY_ADDR = 16'h00e4;
    localparam logic [15:0] THRESH_ADDR = 16'h00e8;
    localparam logic [15:0] STATUS_ADDR = 16'h00ec;

    // Cause bit positions
    localparam int TX_WRITTEN_BIT = 0;
    localparam int TX_EMPTY_BIT = 1;
    localparam int LINK_BIT = 2;
    localparam int RX_ORDER_BIT = 3;
    localparam int RXLOW_BIT = 4;
    localparam int RX_OVERRUN_BIT = 6;
    localparam int RXT_BIT = 7;
    localparam int MGMT_DONE_BIT = 9;
    localparam int RX_CONFIG_BIT = 10;
    localparam int PHY_BIT = 12;
    localparam logic [31:0] CAUSE_VALID = 32'h000016df;

    // Control fields
    localparam int PHY_EN_BIT = 1;
    localparam int INT_PHY_BIT = 0;
    localparam int SERDES_BIT = 1;
    localparam int TX_DELAY_LSB = 0;
    localparam int RX_DELAY_LSB = 16;
    localparam int STAT_LINK_BIT = 0;
    localparam int STAT_TXTMR_BIT = 1;
    localparam int STAT_RXTMR_BIT = 2;
    localparam int STAT_IRQ_BIT = 3;

    // Reset values
    localparam logic [31:0] CAUSE_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] EXT_CTRL_RESET = 32'h00000000;
    localparam logic [31:0] MODE_RESET = 32'h00000000;
    localparam logic [31:0] DELAY_RESET = 32'h00000000;
    localparam logic [31:0] THRESH_RESET = 32'h00000000;

    typedef enum logic [2:0] {
        EIC_SYM_IDLE = 3'h0,
        EIC_SYM_SOF = 3'h1,
        EIC_SYM_DATA = 3'h2,
        EIC_SYM_PAD = 3'h3,
        EIC_SYM_EOF = 3'h4,
        EIC_SYM_FILL = 3'h5
    } eic_sym_type;

    typedef enum logic [3:0] {
        EIC_ST_IDLE = 4'h1,
        EIC_ST_DATA = 4'h2,
        EIC_ST_PAD = 4'h4,
        EIC_ST_END = 4'h8
    } eic_seq_type;

endpackage : eic_pkg

// file: rtl/eic_delay_timer.sv
`timescale 1ns/1ps

// Countdown in clock cycles; a new start re-arms a running count
module eic_delay_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [15:0] load_i,
    output logic busy_o,
    output logic expire_o
);

    logic [15:0] count, next_count;
    logic busy, next_busy;
    logic expire, next_expire;

    always_comb begin
        next_count = count;
        next_busy = busy;
        next_expire = 1'b0;
        if (start_i) begin
            next_count = load_i;
            next_busy = 1'b1;
        end else if (busy) begin
            if (count == 16'h0000) begin
                next_busy = 1'b0;
                next_expire = 1'b1;
            end else begin
                next_count = count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 16'h0000;
            busy <= 1'b0;
            expire <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            expire <= next_expire;
        end
    end

    assign busy_o = busy;
    assign expire_o = expire;

endmodule : eic_delay_timer

// file: rtl/eic_seq_check.sv
`timescale 1ns/1ps

// Checks receive delimiter order: idle, sof, data*, pad*, eof, fill*, idle
module eic_seq_check (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic sym_valid_i,
    input wire eic_pkg::eic_sym_type sym_i,
    output logic error_o
);

    eic_pkg::eic_seq_type state, next_state;
    logic error, next_error;
    logic bad;

    always_comb begin
        next_state = state;
        bad = 1'b0;
        if (sym_valid_i) begin
            case (state)
                eic_pkg::EIC_ST_IDLE: begin
                    if (sym_i == eic_pkg::EIC_SYM_SOF) begin
                        next_state = eic_pkg::EIC_ST_DATA;
                    end else if (sym_i != eic_pkg::EIC_SYM_IDLE) begin
                        bad = 1'b1;
                    end
                end
                eic_pkg::EIC_ST_DATA: begin
                    if (sym_i == eic_pkg::EIC_SYM_PAD) begin
                        next_state = eic_pkg::EIC_ST_PAD;
                    end else if (sym_i == eic_pkg::EIC_SYM_EOF) begin
                        next_state = eic_pkg::EIC_ST_END;
                    end else if (sym_i != eic_pkg::EIC_SYM_DATA) begin
                        bad = 1'b1;
                    end
                end
                eic_pkg::EIC_ST_PAD: begin
                    if (sym_i == eic_pkg::EIC_SYM_EOF) begin
                        next_state = eic_pkg::EIC_ST_END;
                    end else if (sym_i != eic_pkg::EIC_SYM_PAD) begin
                        bad = 1'b1;
                    end
                end
                eic_pkg::EIC_ST_END: begin
                    if (sym_i == eic_pkg::EIC_SYM_IDLE) begin
                        next_state = eic_pkg::EIC_ST_IDLE;
                    end else if (sym_i != eic_pkg::EIC_SYM_FILL) begin
                        bad = 1'b1;
                    end
                end
                default: begin
                    next_state = eic_pkg::EIC_ST_IDLE;
                end
            endcase
            // Resynchronise: a stray start opens a new frame, anything else drops back to the idle state
            if (bad) begin
                next_state = (sym_i == eic_pkg::EIC_SYM_SOF) ? eic_pkg::EIC_ST_DATA
                                                             : eic_pkg::EIC_ST_IDLE;
            end
        end
        if (!enable_i) begin
            next_state = eic_pkg::EIC_ST_IDLE;
        end
        next_error = bad & enable_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= eic_pkg::EIC_ST_IDLE;
            error <= 1'b0;
        end else begin
            state <= next_state;
            error <= next_error;
        end
    end

    assign error_o = error;

endmodule : eic_seq_check

// file: rtl/eic_cause_logic.sv
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Events set sticky cause bits until cleared
// RULE2: Enabled set cause bit requests interrupt
// RULE3: Reading cause returns bits, then clears all
// RULE4: Writing ones clears; zeros leave bits
// RULE5: Bit 0 on reported descriptor, delayed optionally
// RULE6: Bit 1 when transmit queue runs empty
// RULE7: Bit 2 on any link status change
// RULE8: Bit 3 on bad delimiter order, serdes
// RULE9: Bit 4 when free descriptors reach threshold
// RULE10: Bit 6 on receive FIFO overrun
// RULE11: Bit 7 on receive timer expiry, flush
// RULE12: Bit 9 when management access completes
// RULE13: Bit 10 on config symbols in serdes
// RULE14: Bit 12 on enabled PHY interrupt
// RULE15: Event in clearing cycle stays set
// RULE16: Interrupt is OR of masked causes
module eic_cause_logic (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic tx_desc_done_i,
    input wire logic report_status_flag_i,
    input wire logic interrupt_delay_flag_i,
    input wire logic tx_queue_empty_i,
    input wire logic link_up_ext_i,
    input wire logic link_up_int_i,
    input wire logic rx_sym_valid_i,
    input wire eic_pkg::eic_sym_type rx_sym_i,
    input wire logic [15:0] rx_desc_avail_i,
    input wire logic rx_overrun_i,
    input wire logic rx_packet_done_i,
    input wire logic mgmt_access_done_i,
    input wire logic rx_config_symbols_i,
    input wire logic phy_event_i,
    output logic rx_flush_o
);

    logic [31:0] cause, next_cause;
    logic [31:0] mask, next_mask;
    logic [31:0] extended_control, next_extended_control;
    logic [31:0] mode_control, next_mode_control;
    logic [31:0] delay_control, next_delay_control;
    logic [31:0] rx_low_threshold, next_rx_low_threshold;
    logic [31:0] dat, next_dat;
    logic ack, next_ack;
    logic irq, next_irq;
    logic flush, next_flush;
    logic link_prev, next_link_prev;
    logic [15:0] avail_prev, next_avail_prev;

    logic [31:0] events;
    logic [31:0] lane_mask;
    logic [31:0] clear_bits;
    logic [31:0] status_word;
    logic req;
    logic link_now;
    logic serdes_mode;
    logic tx_timer_busy;
    logic tx_timer_expire;
    logic rx_timer_busy;
    logic rx_timer_expire;
    logic seq_error;

    // Byte enables widen to a per-bit write mask
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_mask[8*lane +: 8] = {8{wb_sel_i[lane]}};
        end
    endgenerate

    assign serdes_mode = mode_control[eic_pkg::SERDES_BIT];

    // Internal PHY mode follows the on-chip link indication
    assign link_now = mode_control[eic_pkg::INT_PHY_BIT] ? link_up_int_i : link_up_ext_i; // see RULE7

    eic_delay_timer u_tx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tx_desc_done_i & report_status_flag_i & interrupt_delay_flag_i), // see RULE5
        .load_i(delay_control[eic_pkg::TX_DELAY_LSB +: 16]),
        .busy_o(tx_timer_busy),
        .expire_o(tx_timer_expire)
    );

    // Every finished packet restarts the packing window
    eic_delay_timer u_rx_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(rx_packet_done_i),
        .load_i(delay_control[eic_pkg::RX_DELAY_LSB +: 16]),
        .busy_o(rx_timer_busy),
        .expire_o(rx_timer_expire)
    );

    eic_seq_check u_seq_check (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(serdes_mode),
        .sym_valid_i(rx_sym_valid_i),
        .sym_i(rx_sym_i),
        .error_o(seq_error) // see RULE8
    );

    // Event detection
    always_comb begin
        events = 32'h00000000;
        events[eic_pkg::TX_WRITTEN_BIT] = (tx_desc_done_i & report_status_flag_i
                                     & ~interrupt_delay_flag_i)
                                    | tx_timer_expire; // see RULE5
        events[eic_pkg::TX_EMPTY_BIT] = tx_queue_empty_i; // see RULE6
        events[eic_pkg::LINK_BIT] = link_now ^ link_prev; // see RULE7
        events[eic_pkg::RX_ORDER_BIT] = seq_error; // see RULE8
        // Only the falling crossing counts, so a low level does not retrigger
        events[eic_pkg::RXLOW_BIT] = (rx_desc_avail_i <= rx_low_threshold[15:0])
                                     && (avail_prev > rx_low_threshold[15:0]); // see RULE9
        events[eic_pkg::RX_OVERRUN_BIT] = rx_overrun_i; // see RULE10
        events[eic_pkg::RXT_BIT] = rx_timer_expire; // see RULE11
        events[eic_pkg::MGMT_DONE_BIT] = mgmt_access_done_i; // see RULE12
        events[eic_pkg::RX_CONFIG_BIT] = rx_config_symbols_i & serdes_mode; // see RULE13
        events[eic_pkg::PHY_BIT] = phy_event_i
                                   & extended_control[eic_pkg::PHY_EN_BIT]; // see RULE14
        events = events & eic_pkg::CAUSE_VALID;
        next_link_prev = link_now;
        next_avail_prev = rx_desc_avail_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_prev <= 1'b0;
            avail_prev <= 16'h0000;
        end else begin
            link_prev <= next_link_prev;
            avail_prev <= next_avail_prev;
        end
    end

    // Register file and bus slave
    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack;
        next_ack = req;
        next_dat = 32'h00000000;
        next_mask = mask;
        next_extended_control = extended_control;
        next_mode_control = mode_control;
        next_delay_control = delay_control;
        next_rx_low_threshold = rx_low_threshold;
        clear_bits = 32'h00000000;

        status_word = 32'h00000000;
        status_word[eic_pkg::STAT_LINK_BIT] = link_now;
        status_word[eic_pkg::STAT_TXTMR_BIT] = tx_timer_busy;
        status_word[eic_pkg::STAT_RXTMR_BIT] = rx_timer_busy;
        status_word[eic_pkg::STAT_IRQ_BIT] = irq;

        if (req && wb_we_i) begin
            case (wb_adr_i)
                eic_pkg::CAUSE_ADDR: begin
                    clear_bits = wb_dat_i & lane_mask; // see RULE4
                end
                eic_pkg::MASK_ADDR: begin
                    next_mask = ((mask & ~lane_mask) | (wb_dat_i & lane_mask))
                                & eic_pkg::CAUSE_VALID;
                end
                eic_pkg::EXT_CTRL_ADDR: begin
                    next_extended_control = (extended_control & ~lane_mask)
                                            | (wb_dat_i & lane_mask);
                end
                eic_pkg::MODE_ADDR: begin
                    next_mode_control = (mode_control & ~lane_mask)
                                        | (wb_dat_i & lane_mask);
                end
                eic_pkg::DELAY_ADDR: begin
                    next_delay_control = (delay_control & ~lane_mask)
                                         | (wb_dat_i & lane_mask);
                end
                eic_pkg::THRESH_ADDR: begin
                    next_rx_low_threshold = (rx_low_threshold & ~lane_mask)
                                            | (wb_dat_i & lane_mask);
                end
                default: begin
                    clear_bits = 32'h00000000;
                end
            endcase
        end else if (req) begin
            case (wb_adr_i)
                eic_pkg::CAUSE_ADDR: begin
                    next_dat = cause;
                    clear_bits = 32'hffffffff; // see RULE3
                end
                eic_pkg::MASK_ADDR: begin
                    next_dat = mask;
                end
                eic_pkg::EXT_CTRL_ADDR: begin
                    next_dat = extended_control;
                end
                eic_pkg::MODE_ADDR: begin
                    next_dat = mode_control;
                end
                eic_pkg::DELAY_ADDR: begin
                    next_dat = delay_control;
                end
                eic_pkg::THRESH_ADDR: begin
                    next_dat = rx_low_threshold;
                end
                eic_pkg::STATUS_ADDR: begin
                    next_dat = status_word;
                end
                default: begin
                    next_dat = 32'h00000000;
                end
            endcase
        end

        // New events are ORed after the clear so none is lost
        next_cause = (cause & ~clear_bits) | events; // see RULE1 see RULE15
        next_irq = |(next_cause & next_mask); // see RULE2 see RULE16
        next_flush = rx_timer_expire; // see RULE11
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause <= eic_pkg::CAUSE_RESET;
            mask <= eic_pkg::MASK_RESET;
            extended_control <= eic_pkg::EXT_CTRL_RESET;
            mode_control <= eic_pkg::MODE_RESET;
            delay_control <= eic_pkg::DELAY_RESET;
            rx_low_threshold <= eic_pkg::THRESH_RESET;
            dat <= 32'h00000000;
            ack <= 1'b0;
            irq <= 1'b0;
            flush <= 1'b0;
        end else begin
            cause <= next_cause;
            mask <= next_mask;
            extended_control <= next_extended_control;
            mode_control <= next_mode_control;
            delay_control <= next_delay_control;
            rx_low_threshold <= next_rx_low_threshold;
            dat <= next_dat;
            ack <= next_ack;
            irq <= next_irq;
            flush <= next_flush;
        end
    end

    assign wb_dat_o = dat;
    assign wb_ack_o = ack;
    assign irq_o = irq;
    assign rx_flush_o = flush;

endmodule : eic_cause_logic

// file: verif/eic_irq_monitor.sv
`timescale 1ns/1ps

module eic_irq_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic tx_queue_empty_i,
    input wire logic rx_overrun_i,
    input wire logic mgmt_access_done_i,
    input wire logic rx_flush_o
);
    logic [31:0] mask_copy;
    logic [31:0] next_mask_copy;
    logic req;
    logic mask_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign mask_wr = req && wb_we_i && wb_adr_i == eic_pkg::MASK_ADDR;
    // Mirror of the mask, so the interrupt can be judged from the ports alone
    always_comb begin
        next_mask_copy = mask_copy;
        for (int i = 0; i < 4; i++) begin
            if (mask_wr && wb_sel_i[i]) begin
                next_mask_copy[8*i +: 8] = wb_dat_i[8*i +: 8];
            end
        end
        next_mask_copy = next_mask_copy & eic_pkg::CAUSE_VALID;
    end
    always_ff @(posedge clk_i) begin
        mask_copy <= rst_i ? 32'h0 : next_mask_copy;
    end
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    req_ack_a: assert property (req |=> wb_ack_o)
        else $error("bus request not acknowledged in the next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    rsvd_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == eic_pkg::CAUSE_ADDR)
        |-> (wb_dat_o & ~eic_pkg::CAUSE_VALID) == 32'h0)
        else $error("reserved cause bits read nonzero");
    irq_hold_a: assert property ($fell(irq_o) && !$past(rst_i)
        |-> $past(wb_cyc_i && wb_stb_i))
        else $error("interrupt dropped without a bus access");
    irq_set_a: assert property (((tx_queue_empty_i && mask_copy[eic_pkg::TX_EMPTY_BIT])
        || (rx_overrun_i && mask_copy[eic_pkg::RX_OVERRUN_BIT])
        || (mgmt_access_done_i && mask_copy[eic_pkg::MGMT_DONE_BIT])) && !mask_wr |=> irq_o)
        else $error("enabled event did not raise the interrupt");
    irq_masked_a: assert property (mask_copy == 32'h0 |-> !irq_o)
        else $error("interrupt high with every cause masked");
    flush_pulse_a: assert property (rx_flush_o |=> !rx_flush_o)
        else $error("flush longer than one cycle");
    cover property ($rose(irq_o));
    cover property ($fell(irq_o));
    cover property (rx_flush_o);
endmodule : eic_irq_monitor

bind eic_cause_logic eic_irq_monitor i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .tx_queue_empty_i(tx_queue_empty_i), .rx_overrun_i(rx_overrun_i),
    .mgmt_access_done_i(mgmt_access_done_i), .rx_flush_o(rx_flush_o)
);

// file: verif/eic_host_model.sv
`timescale 1ns/1ps

// Edge-sensitive host input; counts each new request it sees
module eic_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    output logic [7:0] irq_count_o
);
    logic irq_seen;
    logic next_irq_seen;
    logic [7:0] next_irq_count;
    always_comb begin
        next_irq_seen = irq_i;
        next_irq_count = irq_count_o;
        if (irq_i && !irq_seen) begin
            next_irq_count = irq_count_o + 8'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        irq_seen <= rst_i ? 1'b0 : next_irq_seen;
        irq_count_o <= rst_i ? 8'h0 : next_irq_count;
    end
endmodule : eic_host_model

// file: verif/eic_cause_logic_tb_top.sv
`timescale 1ns/1ps

module eic_cause_logic_tb_top;
    logic clk_i, rst_i, wb_req, wb_we, wb_ack, irq, flush, link_ext, link_int, sym_valid;
    logic [15:0] wb_adr, avail;
    logic [31:0] wb_wdat, wb_rdat, rd;
    // Events: tx done, report, delay, queue empty, overrun, packet, mgmt, config, phy
    logic [8:0] ev, ev_req;
    logic [7:0] host_count, cnt0;
    eic_pkg::eic_sym_type sym;
    int n_mismatch, tests_run, n;

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    eic_cause_logic i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .tx_desc_done_i(ev[0]),
        .report_status_flag_i(ev[1]), .interrupt_delay_flag_i(ev[2]),
        .tx_queue_empty_i(ev[3]), .link_up_ext_i(link_ext), .link_up_int_i(link_int),
        .rx_sym_valid_i(sym_valid), .rx_sym_i(sym), .rx_desc_avail_i(avail),
        .rx_overrun_i(ev[4]), .rx_packet_done_i(ev[5]), .mgmt_access_done_i(ev[6]),
        .rx_config_symbols_i(ev[7]), .phy_event_i(ev[8]), .rx_flush_o(flush));
    eic_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .irq_count_o(host_count));

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask : chk

    // Ack and data are taken at a rising edge; ends at a falling edge for settled checks
    task automatic bus(input logic we, input logic [15:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= d;
        ev <= ev_req;
        @(posedge clk_i);
        ev <= 9'h0;
        ev_req = 9'h0;
        while (wb_ack !== 1'b1 && k < 16) begin
            @(posedge clk_i);
            k++;
        end
        if (k == 16) begin
            chk("bus ack", 32'h1, 32'h0);
            summarize();
        end
        rd = wb_rdat;
        wb_req <= 1'b0;
        @(negedge clk_i);
    endtask : bus

    task automatic rdc(input logic [15:0] adr, input logic [31:0] exp, input string name);
        bus(1'b0, adr, 32'h0);
        chk(name, exp, rd);
    endtask : rdc

    task automatic pulse(input logic [8:0] b);
        @(posedge clk_i);
        ev <= b;
        @(posedge clk_i);
        ev <= 9'h0;
        @(negedge clk_i);
    endtask : pulse

    task automatic t_regs;
        rdc(eic_pkg::MASK_ADDR, eic_pkg::MASK_RESET, "mask reset");
        rdc(eic_pkg::DELAY_ADDR, eic_pkg::DELAY_RESET, "delay reset");
        rdc(eic_pkg::CAUSE_ADDR, eic_pkg::CAUSE_RESET, "cause reset");
        bus(1'b1, 16'h0100, 32'hffffffff);
        rdc(16'h0100, 32'h0, "unmapped");
        bus(1'b1, eic_pkg::CAUSE_ADDR, 32'hffffffff);
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "cause after write");
    endtask : t_regs

    task automatic t_sticky;
        pulse(9'h058);
        chk("irq masked", 32'h0, {31'h0, irq});
        cnt0 = host_count;
        bus(1'b1, eic_pkg::MASK_ADDR, 32'h00000040);
        chk("irq enabled", 32'h1, {31'h0, irq});
        chk("host request", {24'h0, cnt0 + 8'h1}, {24'h0, host_count});
        bus(1'b1, eic_pkg::MASK_ADDR, 32'h0);
        chk("irq mask off", 32'h0, {31'h0, irq});
        bus(1'b1, eic_pkg::MASK_ADDR, eic_pkg::CAUSE_VALID);
        rdc(eic_pkg::CAUSE_ADDR, 32'h00000242, "sticky causes");
        chk("irq after read", 32'h0, {31'h0, irq});
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "read clears");
    endtask : t_sticky

    task automatic t_clear;
        pulse(9'h018);
        bus(1'b1, eic_pkg::CAUSE_ADDR, 32'h00000002);
        rdc(eic_pkg::CAUSE_ADDR, 32'h00000040, "write one clear");
        ev_req = 9'h040;
        bus(1'b0, eic_pkg::CAUSE_ADDR, 32'h0);
        rdc(eic_pkg::CAUSE_ADDR, 32'h00000200, "event during read");
        ev_req = 9'h008;
        bus(1'b1, eic_pkg::CAUSE_ADDR, 32'h00000002);
        rdc(eic_pkg::CAUSE_ADDR, 32'h00000002, "event during write");
    endtask : t_clear

    task automatic t_tx;
        pulse(9'h003);
        rdc(eic_pkg::CAUSE_ADDR, 32'h1, "tx report");
        pulse(9'h001);
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "tx no report");
        bus(1'b1, eic_pkg::DELAY_ADDR, 32'h00050008);
        pulse(9'h007);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("tx delay window", 32'h1, {31'h0, n >= 7 && n <= 12});
        rdc(eic_pkg::CAUSE_ADDR, 32'h1, "tx delayed");
    endtask : t_tx

    task automatic t_link;
        @(posedge clk_i);
        link_ext <= 1'b1;
        rdc(eic_pkg::CAUSE_ADDR, 32'h4, "link up");
        @(posedge clk_i);
        link_ext <= 1'b0;
        rdc(eic_pkg::CAUSE_ADDR, 32'h4, "link down");
        bus(1'b1, eic_pkg::MODE_ADDR, 32'h1);
        @(posedge clk_i);
        link_int <= 1'b1;
        rdc(eic_pkg::CAUSE_ADDR, 32'h4, "internal link");
    endtask : t_link

    task automatic send(input logic [23:0] s, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk_i);
            sym_valid <= 1'b1;
            sym <= eic_pkg::eic_sym_type'(s[3*i +: 3]);
        end
        @(posedge clk_i);
        sym_valid <= 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : send

    task automatic t_serdes;
        bus(1'b1, eic_pkg::MODE_ADDR, 32'h3);
        send(24'h02c688, 7);
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "good frame");
        send(24'h000010, 2);
        rdc(eic_pkg::CAUSE_ADDR, 32'h8, "bad order");
        pulse(9'h080);
        rdc(eic_pkg::CAUSE_ADDR, 32'h400, "config symbols");
        bus(1'b1, eic_pkg::MODE_ADDR, 32'h1);
        pulse(9'h080);
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "config off serdes");
    endtask : t_serdes

    task automatic t_misc;
        bus(1'b1, eic_pkg::THRESH_ADDR, 32'habcd0002);
        rdc(eic_pkg::THRESH_ADDR, 32'habcd0002, "threshold");
        @(posedge clk_i);
        avail <= 16'h0003;
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "above threshold");
        @(posedge clk_i);
        avail <= 16'h0002;
        rdc(eic_pkg::CAUSE_ADDR, 32'h10, "at threshold");
        pulse(9'h020);
        n = 0;
        while (flush !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk("rx flush", 32'h1, {31'h0, flush});
        rdc(eic_pkg::CAUSE_ADDR, 32'h80, "rx timer");
        pulse(9'h100);
        rdc(eic_pkg::CAUSE_ADDR, 32'h0, "phy disabled");
        bus(1'b1, eic_pkg::EXT_CTRL_ADDR, 32'h2);
        pulse(9'h100);
        rdc(eic_pkg::CAUSE_ADDR, 32'h1000, "phy event");
    endtask : t_misc

    initial begin
        rst_i = 1'b1;
        {wb_req, wb_we, link_ext, link_int, sym_valid} = 5'h0;
        wb_adr = 16'h0;
        wb_wdat = 32'h0;
        ev = 9'h0;
        ev_req = 9'h0;
        sym = eic_pkg::EIC_SYM_IDLE;
        avail = 16'h0010;
        n_mismatch = 0;
        tests_run = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_sticky();
        t_clear();
        t_tx();
        t_link();
        t_serdes();
        t_misc();
        summarize();
    end
endmodule : eic_cause_logic_tb_top
